// ---- rtl/adcr_ctrl.sv ----
// apb register front end and sequencing for the 12-bit converter
`timescale 1ns/10ps
`default_nettype none
module adcr_ctrl #(
    parameter int EIGHT_CH  = 0,  // 1 selects eight-channel variant
    parameter int NUM_PINS  = 8   // shared analog pins
) (
    input  wire logic                pclk,          // system clock
    input  wire logic                presetn,       // async reset, low
    input  wire logic                psel,          // apb select
    input  wire logic                penable,       // apb access phase
    input  wire logic                pwrite,        // apb direction
    input  wire logic [11:0]         paddr,         // apb byte address
    input  wire logic [31:0]         pwdata,        // apb write data
    output logic      [31:0]         prdata,        // apb read data
    output logic                     pready,        // apb ready
    output logic                     pslverr,       // apb error
    input  wire logic                core_done,     // core finished (async)
    input  wire logic [11:0]         core_data,     // core result, stable at done
    output logic                     core_reset,    // core reset pulse
    output logic                     core_start,    // core start pulse
    output logic                     core_enable,   // core power enable
    output logic                     core_clk_en,   // conversion clock tick
    output logic [2:0]               ext_channel,   // routed external input
    output logic                     use_internal,  // internal source routed
    output logic [2:0]               int_source,    // effective source code
    output logic [3:0]               ref_select,    // effective reference code
    output logic                     amp_enable,    // amplifier enable
    output logic                     bandgap_en,    // bandgap buffer enable
    output logic [NUM_PINS-1:0]      pin_analog,    // pin taken as analog
    output logic [NUM_PINS-1:0]      pin_pullup_ok, // pull-up allowed
    output logic                     conv_irq_flag  // completion request flag
);
    import adcr_pkg::*;

    // configuration registers and their next values
    logic [7:0]  main_r;
    logic [7:0]  main_nxt;
    logic [7:0]  src_r;
    logic [7:0]  src_nxt;
    logic [7:0]  ref_r;
    logic [7:0]  ref_nxt;
    logic [7:0]  pina_r;
    logic [7:0]  pina_nxt;
    logic [7:0]  pinb_r;
    logic [7:0]  pinb_nxt;
    // result, status and read data
    logic [11:0] res_r;
    logic [11:0] res_nxt;
    logic        busy_r;
    logic        busy_nxt;
    logic        flag_r;
    logic        flag_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    // completion synchroniser and edge memory
    logic [2:0]  done_sync_r;
    logic        done_seen_r;
    logic        done_seen_nxt;
    logic        done_agree;
    // conversion clock divider
    logic [6:0]  div_r;
    logic [6:0]  div_nxt;
    logic        tick_r;
    logic        tick_nxt;
    // sequencer
    adcr_state_t st_r;
    adcr_state_t st_nxt;
    // decoded strobes and justified views
    logic        wr;
    logic        rd;
    logic        wr_main;
    logic        start_rise;
    logic        start_fall;
    logic        done_rise;
    logic [7:0]  main_mask;
    logic [7:0]  res_low_v;
    logic [7:0]  res_high_v;

    // true for every implemented register offset
    function automatic logic addr_mapped(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        if (a == ADCR_OFS_RES_LOW) begin
            hit = 1'b1;
        end else if (a == ADCR_OFS_RES_HIGH) begin
            hit = 1'b1;
        end else if (a == ADCR_OFS_MAIN) begin
            hit = 1'b1;
        end else if (a == ADCR_OFS_SRC_CLK) begin
            hit = 1'b1;
        end else if (a == ADCR_OFS_REF) begin
            hit = 1'b1;
        end else if (a == ADCR_OFS_PIN_A) begin
            hit = 1'b1;
        end else if (a == ADCR_OFS_PIN_B) begin
            hit = 1'b1;
        end else if (a == ADCR_OFS_FLAG) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : addr_mapped

    // code lies inside an inclusive range
    function automatic logic code_in(input logic [3:0] c, input logic [3:0] lo, input logic [3:0] hi);
        return c >= lo && c <= hi;
    endfunction : code_in

    // variant-dependent writable bits of main control
    assign main_mask = (EIGHT_CH != 0) ? ADCR_MASK_MAIN8 : ADCR_MASK_MAIN4;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;

    // justified views of the result
    always_comb begin
        if (main_r[ADCR_BIT_JUSTIFY]) begin
            res_high_v = {4'h0, res_r[11:8]};
            res_low_v  = res_r[7:0];
        end else begin
            res_high_v = res_r[11:4];
            res_low_v  = {res_r[3:0], 4'h0};
        end
    end

    // done input synchroniser; change counted when stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_sync_r <= 3'h0;
        end else begin
            done_sync_r <= {done_sync_r[1:0], core_done};
        end
    end

    // start bit edges on main control writes, completion edge
    assign wr_main    = wr && paddr == ADCR_OFS_MAIN;
    assign start_rise = wr_main && pwdata[ADCR_BIT_START] && !main_r[ADCR_BIT_START];
    assign start_fall = wr_main && !pwdata[ADCR_BIT_START] && main_r[ADCR_BIT_START];
    assign done_agree = done_sync_r[2] == done_sync_r[1];
    assign done_rise  = done_agree && done_sync_r[2] && !done_seen_r;

    // register writes, sequencing and core pulses
    always_comb begin
        main_nxt = main_r;
        src_nxt = src_r;
        ref_nxt = ref_r;
        pina_nxt = pina_r;
        pinb_nxt = pinb_r;
        res_nxt = res_r;       // kept regardless of enable
        busy_nxt = busy_r;
        flag_nxt = flag_r;
        st_nxt = st_r;
        done_seen_nxt = done_agree ? done_sync_r[2] : done_seen_r;
        pslverr = 1'b0;
        core_reset = 1'b0;
        core_start = 1'b0;
        if (psel && !addr_mapped(paddr)) begin
            pslverr = penable;
        end
        if (wr) begin
            if (paddr == ADCR_OFS_MAIN) begin
                main_nxt = pwdata[7:0] & main_mask;
            end else if (paddr == ADCR_OFS_SRC_CLK) begin
                src_nxt = pwdata[7:0] & ADCR_MASK_SRC;
            end else if (paddr == ADCR_OFS_REF) begin
                ref_nxt = pwdata[7:0] & ADCR_MASK_REF;
            end else if (paddr == ADCR_OFS_PIN_A) begin
                pina_nxt = pwdata[7:0];
            end else if (paddr == ADCR_OFS_PIN_B) begin
                pinb_nxt = pwdata[7:0];
            end else if (paddr == ADCR_OFS_FLAG) begin
                if (pwdata[0]) begin
                    flag_nxt = 1'b0;  // write one clears
                end
            end
        end
        case (st_r)
            ADCR_IDLE: begin
                if (start_rise) begin
                    st_nxt = ADCR_ARMED;
                end
            end
            ADCR_ARMED: begin
                if (start_fall) begin
                    st_nxt = ADCR_CONV;
                end
            end
            ADCR_CONV: begin
                if (start_rise) begin
                    st_nxt = ADCR_ARMED;
                end else if (done_rise) begin
                    st_nxt = ADCR_IDLE;
                end
            end
            default: st_nxt = ADCR_IDLE;
        endcase
        if (start_rise) begin
            core_reset = 1'b1;
            busy_nxt = 1'b0;
        end else if (start_fall && st_r == ADCR_ARMED) begin
            core_start = 1'b1;
            busy_nxt = 1'b1;
        end else if (st_r == ADCR_CONV && done_rise) begin
            res_nxt = core_data; // result lands with busy clearing
            busy_nxt = 1'b0;
            flag_nxt = 1'b1;     // set beats clear
        end
    end

    // read mux, loaded in the setup cycle
    always_comb begin
        prdata_nxt = prdata_r;
        if (rd) begin
            prdata_nxt = 32'h0;
            if (paddr == ADCR_OFS_RES_LOW) begin
                prdata_nxt[7:0] = res_low_v;
            end else if (paddr == ADCR_OFS_RES_HIGH) begin
                prdata_nxt[7:0] = res_high_v;
            end else if (paddr == ADCR_OFS_MAIN) begin
                prdata_nxt[7:0] = main_r;
                prdata_nxt[ADCR_BIT_BUSY] = busy_r;
            end else if (paddr == ADCR_OFS_SRC_CLK) begin
                prdata_nxt[7:0] = src_r;
            end else if (paddr == ADCR_OFS_REF) begin
                prdata_nxt[7:0] = ref_r;
            end else if (paddr == ADCR_OFS_PIN_A) begin
                prdata_nxt[7:0] = pina_r;
            end else if (paddr == ADCR_OFS_PIN_B) begin
                prdata_nxt[7:0] = pinb_r;
            end else if (paddr == ADCR_OFS_FLAG) begin
                prdata_nxt[0] = flag_r;
            end
        end
    end

    // conversion clock divider: tick every 2^code system clocks
    always_comb begin
        div_nxt = div_r + 7'h1;
        tick_nxt = 1'b0;
        if (div_r >= 7'((1 << src_r[2:0]) - 1)) begin
            div_nxt = 7'h0;
            tick_nxt = main_r[ADCR_BIT_ENABLE];
        end
    end

    // main control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_r <= ADCR_RST_BYTE;
        end else begin
            main_r <= main_nxt;
        end
    end

    // source and clock select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_r <= ADCR_RST_BYTE;
        end else begin
            src_r <= src_nxt;
        end
    end

    // reference register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_r <= ADCR_RST_BYTE;
        end else begin
            ref_r <= ref_nxt;
        end
    end

    // pin takeover, port a
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pina_r <= ADCR_RST_BYTE;
        end else begin
            pina_r <= pina_nxt;
        end
    end

    // pin takeover, port b
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pinb_r <= ADCR_RST_BYTE;
        end else begin
            pinb_r <= pinb_nxt;
        end
    end

    // conversion result, kept while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_r <= 12'h0;
        end else begin
            res_r <= res_nxt;
        end
    end

    // busy and completion flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            flag_r <= flag_nxt;
        end
    end

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ADCR_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // read data, stands until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // last agreed completion level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_seen_r <= 1'b0;
        end else begin
            done_seen_r <= done_seen_nxt;
        end
    end

    // divider count and tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 7'h0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // source choice, internal over external
    always_comb begin
        int_source = src_r[7:5];
        use_internal = 1'b0;
        if (code_in({1'b0, src_r[7:5]}, {1'b0, ADCR_SRC_SUP_LO}, {1'b0, ADCR_SRC_SUP_HI})
            || code_in({1'b0, src_r[7:5]}, {1'b0, ADCR_SRC_AMP_LO}, {1'b0, ADCR_SRC_AMP_HI})) begin
            use_internal = 1'b1;
        end else begin
            int_source = ADCR_SRC_EXT;
        end
    end

    // reference choice, bandgap over pin
    always_comb begin
        ref_select = ADCR_REF_SUPPLY;
        if (code_in(ref_r[3:0], ADCR_REF_BG_LO, ADCR_REF_BG_HI)) begin
            ref_select = ref_r[3:0];    // bandgap preferred
        end else if (code_in(ref_r[3:0], ADCR_REF_PIN_LO, ADCR_REF_PIN_HI)) begin
            ref_select = ref_r[3:0];
        end
    end

    assign ext_channel = (EIGHT_CH != 0) ? main_r[2:0] : {1'b0, main_r[1:0]};
    assign core_enable = main_r[ADCR_BIT_ENABLE];
    assign core_clk_en = tick_r;
    assign amp_enable = ref_r[7];
    assign bandgap_en = ref_r[6];
    assign pin_analog = NUM_PINS'({pinb_r, pina_r});
    assign pin_pullup_ok = ~NUM_PINS'({pinb_r, pina_r});
    assign conv_irq_flag = flag_r;
endmodule : adcr_ctrl
`default_nettype wire

// ---- rtl/adcr_pkg.sv ----
// constants and register map for the converter control block
package adcr_pkg;
    // register byte addresses
    localparam logic [11:0] ADCR_OFS_RES_LOW  = 12'h000;
    localparam logic [11:0] ADCR_OFS_RES_HIGH = 12'h004;
    localparam logic [11:0] ADCR_OFS_MAIN     = 12'h008;
    localparam logic [11:0] ADCR_OFS_SRC_CLK  = 12'h00c;
    localparam logic [11:0] ADCR_OFS_REF      = 12'h010;
    localparam logic [11:0] ADCR_OFS_PIN_A    = 12'h014;
    localparam logic [11:0] ADCR_OFS_PIN_B    = 12'h018;
    localparam logic [11:0] ADCR_OFS_FLAG     = 12'h01c;
    // main control fields
    localparam int ADCR_BIT_START  = 7;
    localparam int ADCR_BIT_BUSY   = 6;
    localparam int ADCR_BIT_ENABLE = 5;
    localparam int ADCR_BIT_JUSTIFY = 4;
    localparam logic [7:0] ADCR_MASK_MAIN4 = 8'hb3;
    localparam logic [7:0] ADCR_MASK_MAIN8 = 8'hb7;
    localparam logic [7:0] ADCR_MASK_SRC   = 8'he7;
    localparam logic [7:0] ADCR_MASK_REF   = 8'hcf;
    localparam logic [7:0] ADCR_RST_BYTE   = 8'h00;
    // source select codes
    localparam logic [2:0] ADCR_SRC_EXT     = 3'h0;
    localparam logic [2:0] ADCR_SRC_SUP_LO  = 3'h1;
    localparam logic [2:0] ADCR_SRC_SUP_HI  = 3'h3;
    localparam logic [2:0] ADCR_SRC_AMP_LO  = 3'h5;
    localparam logic [2:0] ADCR_SRC_AMP_HI  = 3'h7;
    // reference codes: 0xa to 0xc mean bandgap path
    localparam logic [3:0] ADCR_REF_SUPPLY  = 4'h0;
    localparam logic [3:0] ADCR_REF_PIN_LO  = 4'h1;
    localparam logic [3:0] ADCR_REF_PIN_HI  = 4'h4;
    localparam logic [3:0] ADCR_REF_BG_LO   = 4'ha;
    localparam logic [3:0] ADCR_REF_BG_HI   = 4'hc;
    // conversion length in converter clocks
    localparam int ADCR_CONV_CLKS = 16;
    typedef enum logic [2:0] {
        ADCR_IDLE  = 3'b001,
        ADCR_ARMED = 3'b010,
        ADCR_CONV  = 3'b100
    } adcr_state_t;
endpackage : adcr_pkg

// ---- tb/adcr_core_model.sv ----
// behavioural analog core: converts after a fixed count of ticks
`timescale 1ns/10ps
`default_nettype none
module adcr_core_model #(
    parameter int TICKS = 16  // ticks per conversion
) (
    input  wire logic        pclk,        // clock
    input  wire logic        presetn,     // reset, low
    input  wire logic        core_reset,  // abort
    input  wire logic        core_start,  // start
    input  wire logic        core_clk_en, // tick
    input  wire logic [11:0] sample,      // analog value
    output logic             core_done,   // done level
    output logic [11:0]      core_data    // result
);
    int   cnt;
    logic run;
    // data scrambled while done is low, held while done is high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            cnt <= 0;
            core_done <= 1'b0;
            core_data <= 12'h000;
        end else if (core_reset || core_start) begin
            run <= core_start;
            cnt <= 0;
            core_done <= 1'b0;
            core_data <= ~core_data;
        end else if (run && core_clk_en) begin
            cnt <= cnt + 1;
            run <= (cnt < TICKS - 1);
            core_done <= (cnt == TICKS - 1);
            core_data <= (cnt == TICKS - 1) ? sample : ~core_data;
        end
    end
endmodule : adcr_core_model
`default_nettype wire

// ---- tb/adcr_ctrl_props.sv ----
// port checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcr_ctrl_props #(
    parameter int EIGHT_CH = 0,  // variant
    parameter int NUM_PINS = 8   // shared pins
) (
    input wire logic                pclk,          // clock
    input wire logic                presetn,       // reset
    input wire logic                psel,          // select
    input wire logic                penable,       // access
    input wire logic                pwrite,        // write
    input wire logic [11:0]         paddr,         // address
    input wire logic [31:0]         pwdata,        // wdata
    input wire logic [31:0]         prdata,        // rdata
    input wire logic                pslverr,       // error
    input wire logic                core_done,     // done
    input wire logic                core_reset,    // abort
    input wire logic                core_start,    // start
    input wire logic                core_enable,   // enable
    input wire logic [2:0]          ext_channel,   // channel
    input wire logic                use_internal,  // internal
    input wire logic [2:0]          int_source,    // source
    input wire logic [3:0]          ref_select,    // reference
    input wire logic [NUM_PINS-1:0] pin_analog,    // analog
    input wire logic [NUM_PINS-1:0] pin_pullup_ok, // pull-up
    input wire logic                conv_irq_flag  // flag
);
    import adcr_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phases of main writes and of reads
    sequence wr_main_s;
        psel && penable && pwrite && paddr == ADCR_OFS_MAIN;
    endsequence
    sequence rd_acc_s;
        psel && penable && !pwrite;
    endsequence
    AST_RESET_CAUSE: assert property (core_reset |-> wr_main_s ##0 pwdata[7])
        else $error("core reset without start write");
    AST_START_CAUSE: assert property (core_start |-> wr_main_s ##0 !pwdata[7] && !core_reset)
        else $error("core start without start clear");
    AST_ENABLE: assert property (wr_main_s |=> core_enable == $past(pwdata[5]))
        else $error("enable not following write");
    AST_CHANNEL: assert property (wr_main_s |=> ext_channel == ($past(pwdata[2:0]) & (EIGHT_CH ? 3'h7 : 3'h3)))
        else $error("channel not following write");
    AST_INTERNAL: assert property (use_internal |-> int_source != ADCR_SRC_EXT && int_source != 3'h4)
        else $error("internal path with external code");
    AST_REF: assert property (ref_select inside {[4'h0:4'h4], [4'ha:4'hc]})
        else $error("illegal reference code");
    AST_PULLUP: assert property (pin_pullup_ok == ~pin_analog)
        else $error("pull-up on analog pin");
    AST_DONE_FLAG: assert property ($rose(core_done) |-> ##[1:6] conv_irq_flag)
        else $error("completion flag missing");
    AST_UNMAPPED: assert property (psel && penable && (paddr > ADCR_OFS_FLAG || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not refused");
    AST_READ_ZERO: assert property (rd_acc_s |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
endmodule : adcr_ctrl_props
bind adcr_ctrl adcr_ctrl_props #(.EIGHT_CH(EIGHT_CH), .NUM_PINS(NUM_PINS)) adcr_ctrl_props_i (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import adcr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, j, bandgap_en;
    logic        core_done, core_reset, core_start, core_enable, core_clk_en, use_internal, amp_enable, conv_irq_flag;
    logic [11:0] paddr, sample, core_data;
    logic [31:0] pwdata, prdata, exp_q[$];
    logic [2:0]  ext_channel, int_source;
    logic [3:0]  ref_select;
    logic [15:0] pin_analog;
    logic [7:0]  pa, pb, lo, hi, mc;
    int          failures = 0, num_checks = 0, n;
    adcr_ctrl #(.EIGHT_CH(0), .NUM_PINS(16)) adcr_ctrl_i (.*, .pin_pullup_ok());
    adcr_core_model #(.TICKS(ADCR_CONV_CLKS)) adcr_core_model_i (.*);
    always #50 pclk = ~pclk;
    // compare tasks for read data and for port levels
    task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask : check_rd
    task automatic check_pin(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t port %h expected %h", $time, got, exp);
        end
    endtask : check_pin
    // one apb transfer; a read notes its expected byte
    task automatic xfer(input logic [11:0] a, input logic wr, input logic [7:0] d);
        @(posedge pclk);
        if (!wr) exp_q.push_back({24'h000000, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : xfer
    // read results checked as each access completes
    always @(posedge pclk)
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
            check_rd(prdata, exp_q.pop_front());
            check_pin(32'(pslverr), 32'(paddr > ADCR_OFS_FLAG));
        end
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    // hang guard
    initial begin
        #4000000;
        failures++;
        end_sim();
    end
    // main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, sample} = '0;
        void'($urandom(61865));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 32; a += 4) xfer(a[11:0], 1'b0, 8'h00);
        xfer(12'h020, 1'b1, 8'hff);
        xfer(ADCR_OFS_MAIN, 1'b1, 8'hff);
        xfer(ADCR_OFS_MAIN, 1'b0, ADCR_MASK_MAIN4);
        for (int c = 0; c < 8; c++) begin
            xfer(ADCR_OFS_SRC_CLK, 1'b1, {c[2:0], 5'h1f});
            check_pin(32'(use_internal), 32'(c != 0 && c != 4));
            check_pin(32'(int_source), (c != 0 && c != 4) ? 32'(c) : 32'h0);
            xfer(ADCR_OFS_SRC_CLK, 1'b0, {c[2:0], 5'h07});
        end
        xfer(ADCR_OFS_SRC_CLK, 1'b1, 8'h00);
        pa = 8'($urandom);
        pb = 8'($urandom);
        xfer(ADCR_OFS_PIN_A, 1'b1, pa);
        xfer(ADCR_OFS_PIN_B, 1'b1, pb);
        check_pin(32'(pin_analog), {16'h0000, pb, pa});
        xfer(ADCR_OFS_REF, 1'b1, 8'hfc);
        check_pin({26'h0, amp_enable, bandgap_en, ref_select}, 32'h3c);
        xfer(ADCR_OFS_REF, 1'b1, 8'h09);
        check_pin({26'h0, amp_enable, bandgap_en, ref_select}, 32'h0);
        xfer(ADCR_OFS_REF, 1'b0, 8'h09);
        for (int i = 0; i < 6; i++) begin
            j = i[0];
            sample = 12'($urandom);
            mc = {3'b001, j, 2'b00, 2'($urandom)};
            lo = j ? sample[7:0] : {sample[3:0], 4'h0};
            hi = j ? {4'h0, sample[11:8]} : sample[11:4];
            xfer(ADCR_OFS_MAIN, 1'b1, mc | 8'h80);
            xfer(ADCR_OFS_MAIN, 1'b1, mc);
            xfer(ADCR_OFS_MAIN, 1'b0, mc | 8'h40);
            check_pin(32'(ext_channel), 32'(mc[1:0]));
            for (n = 0; n < 300 && conv_irq_flag !== 1'b1; n++) @(posedge pclk);
            check_pin(32'(conv_irq_flag), 32'h1);
            xfer(ADCR_OFS_MAIN, 1'b0, mc);
            xfer(ADCR_OFS_FLAG, 1'b1, 8'h01);
            check_pin(32'(conv_irq_flag), 32'h0);
            xfer(ADCR_OFS_MAIN, 1'b1, mc & 8'h10);
            check_pin(32'(core_enable), 32'h0);
            xfer(ADCR_OFS_RES_LOW, 1'b0, lo);
            xfer(ADCR_OFS_RES_HIGH, 1'b0, hi);
        end
        // start raised again mid conversion aborts it
        xfer(ADCR_OFS_MAIN, 1'b1, 8'ha0);
        xfer(ADCR_OFS_MAIN, 1'b1, 8'h20);
        xfer(ADCR_OFS_MAIN, 1'b1, 8'ha0);
        xfer(ADCR_OFS_MAIN, 1'b0, 8'ha0);
        repeat (40) @(posedge pclk);
        check_pin(32'(conv_irq_flag), 32'h0);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
